// *** design/i2c_flag_pkg.sv ***
// Register map, field positions and reset values of the two-wire status flag block.
package i2c_flag_pkg;
	// Register byte addresses (one aligned 32-bit word each)
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_OWN_ADDRESS = 8'h04;
	localparam logic [7:0] OFF_STATUS_PRIMARY = 8'h08;
	localparam logic [7:0] OFF_STATUS_SECONDARY = 8'h0C;
	localparam logic [7:0] OFF_DATA_BUFFER = 8'h10;

	// Control register fields
	localparam int CTL_INTERFACE_ENABLE = 0;
	localparam int CTL_EVENT_IRQ_ENABLE = 1;
	localparam int CTL_ACK_ENABLE = 2;
	localparam int CTL_GENERAL_CALL_ENABLE = 3;
	localparam int CTL_START_REQUEST = 4;

	// Primary status fields
	localparam int SP_EVENT_PENDING = 7;
	localparam int SP_TEN_BIT_HEADER_SENT = 6;
	localparam int SP_DIRECTION_TRANSMIT = 5;
	localparam int SP_BUS_BUSY = 4;
	localparam int SP_BYTE_DONE = 3;
	localparam int SP_OWN_ADDRESS_HIT = 2;
	localparam int SP_MASTER_ROLE = 1;
	localparam int SP_START_GENERATED = 0;

	// Secondary status fields; bits 7:5 read as zero
	localparam int SS_ACK_MISSING = 4;
	localparam int SS_STOP_SEEN = 3;
	localparam int SS_ARBITRATION_LOST = 2;
	localparam int SS_BUS_FAULT = 1;
	localparam int SS_GENERAL_CALL_SEEN = 0;

	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [6:0] RST_OWN_ADDRESS = 7'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;
endpackage

// *** design/i2c_status_flag_logic.sv ***
// Status flags, clock stretching and register slave of the two-wire bus interface.
`timescale 1ns/1ps
`default_nettype none

// Function
// - event_pending rises on any event; error flags clear by second status read; disable clears.
// - event_pending sources: all event flags plus a master address byte sent.
// - ten_bit_header_sent set after header; cleared by second status read then data write.
// - direction_transmit tells tx or rx with byte_done; clears with it, stop, arbitration loss.
// - bus busy set on Start, cleared on Stop or bus fault.
// - byte_done set per finished byte; cleared by first status read then data access.
// - tx byte_done after ack pulse or address phase done; cleared by next byte write.
// - rx byte_done after driven ack pulse if ack enabled; cleared by data read.
// - clock line held low while byte_done is set.
// - own_address_hit on address match or general call; cleared by first status read.
// - clock line held low while own_address_hit is set.
// - master_role set by start request; cleared on Stop, arbitration loss, disable.
// - start_generated after requested Start; cleared by first status read then address write.
// - upper three bits of second status read zero.
// - ack_missing set when no acknowledge; cleared by second status read.
// - ack_missing alone never holds the clock line.
// - stop_seen in slave mode after acknowledge with ack enabled; never stretches clock.
// - arbitration_lost set on lost bus; returns to slave; no stretching.
// - bus_fault set on misplaced Start or Stop; no stretching.
// - general_call_seen set on general call while enabled; cleared on stop_seen.
module i2c_status_flag_logic (
	input wire logic clock, // 20 MHz system clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte enables
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic scl_i, // Bus clock line level
	output logic scl_o, // Bus clock drive value
	output logic scl_oe_n, // Bus clock drive enable, low drives
	input wire logic sda_i, // Bus data line level
	input wire logic ev_start_done, // Pulse: requested Start produced
	input wire logic ev_addr_sent, // Pulse: master address byte acknowledged
	input wire logic ev_header_sent, // Pulse: 10-bit header byte sent
	input wire logic ev_addr_phase_done, // Pulse: address phase complete
	input wire logic ev_tx_ack_pulse, // Pulse: ack clock of sent byte received
	input wire logic ev_rx_ack_pulse, // Pulse: ack clock of received byte driven
	input wire logic ev_no_ack, // Pulse: no acknowledge returned
	input wire logic ev_arb_lost, // Pulse: another master won the bus
	input wire logic ev_misplaced, // Pulse: misplaced Start or Stop
	input wire logic ev_addr_rx, // Pulse: slave address received
	input wire logic [6:0] rx_addr, // Received slave address
	input wire logic [7:0] rx_data, // Last received data byte
	output logic [7:0] tx_data, // Byte written by software
	output logic tx_load, // Pulse: new byte written
	output logic start_request, // Pulse: software asked for a Start
	output logic interface_enable, // Interface enable level
	output logic ack_enable, // Acknowledge enable level
	output logic general_call_enable, // General call enable level
	output logic [6:0] own_address, // Own slave address
	output logic irq // Shared interrupt, active high
);
	logic event_irq_enable;
	logic event_pending, ten_bit_header_sent, direction_transmit, bus_busy;
	logic byte_done, own_address_hit, master_role, start_generated;
	logic ack_missing, stop_seen, arbitration_lost, bus_fault, general_call_seen;
	logic addr_sent_flag, ack_since_start;
	logic primary_armed, secondary_armed;
	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	logic next_byte_done, next_own_address_hit, next_start_generated, next_ten_bit_header_sent;
	logic next_ack_missing, next_stop_seen, next_arbitration_lost, next_bus_fault, next_addr_sent_flag;
	logic access, wr, rd, wr_lane, disabled;
	logic sel_ctl, sel_own, sel_sp, sel_ss, sel_dr;
	logic rd_sp, rd_ss, dr_read, dr_write, dr_access;
	logic start_cond, stop_cond, stop_flag_set, addr_match, gc_match;
	logic [7:0] status_primary, status_secondary;

	// A new request is taken only while ack is low, so each access acts once
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = access && wb_we_i;
	assign rd = access && !wb_we_i;
	assign wr_lane = wr && wb_sel_i[0];
	assign sel_ctl = wb_adr_i == i2c_flag_pkg::OFF_CONTROL;
	assign sel_own = wb_adr_i == i2c_flag_pkg::OFF_OWN_ADDRESS;
	assign sel_sp = wb_adr_i == i2c_flag_pkg::OFF_STATUS_PRIMARY;
	assign sel_ss = wb_adr_i == i2c_flag_pkg::OFF_STATUS_SECONDARY;
	assign sel_dr = wb_adr_i == i2c_flag_pkg::OFF_DATA_BUFFER;
	assign rd_sp = rd && sel_sp;
	assign rd_ss = rd && sel_ss;
	assign dr_read = rd && sel_dr;
	assign dr_write = wr_lane && sel_dr;
	assign dr_access = dr_read || dr_write;
	assign disabled = !interface_enable;

	// Bus lines pass two flops; third stage only for edge finding
	always_ff @(posedge clock) begin
		if (srst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	assign start_cond = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign stop_cond = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
	assign addr_match = ev_addr_rx && (rx_addr == own_address);
	assign gc_match = ev_addr_rx && general_call_enable && (rx_addr == i2c_flag_pkg::GENERAL_CALL_ADDRESS);
	assign stop_flag_set = stop_cond && !master_role && ack_enable && ack_since_start;

	// Set terms win over clear terms in every flag below
	always_comb begin
		next_byte_done = ev_tx_ack_pulse || ev_addr_phase_done
			|| (ev_rx_ack_pulse && ack_enable)
			|| (byte_done && !(primary_armed && dr_access) && !disabled);
		next_own_address_hit = addr_match || gc_match || (own_address_hit && !rd_sp && !disabled);
		next_start_generated = ev_start_done || (start_generated && !(primary_armed && dr_write) && !disabled);
		next_ten_bit_header_sent = ev_header_sent
			|| (ten_bit_header_sent && !(secondary_armed && dr_write) && !disabled);
		next_addr_sent_flag = ev_addr_sent || (addr_sent_flag && !(primary_armed && dr_access) && !disabled);
		next_ack_missing = ev_no_ack || (ack_missing && !rd_ss && !disabled);
		next_stop_seen = stop_flag_set || (stop_seen && !rd_ss && !disabled);
		next_arbitration_lost = ev_arb_lost || (arbitration_lost && !rd_ss && !disabled);
		next_bus_fault = ev_misplaced || (bus_fault && !rd_ss && !disabled);
	end

	// Transfer flags; disabling the interface clears them all
	always_ff @(posedge clock) begin
		if (srst) begin
			byte_done <= 1'b0;
			own_address_hit <= 1'b0;
			start_generated <= 1'b0;
			ten_bit_header_sent <= 1'b0;
			addr_sent_flag <= 1'b0;
		end else begin
			byte_done <= next_byte_done;
			own_address_hit <= next_own_address_hit;
			start_generated <= next_start_generated;
			ten_bit_header_sent <= next_ten_bit_header_sent;
			addr_sent_flag <= next_addr_sent_flag;
		end
	end

	// Error flags, all cleared by one secondary status read
	always_ff @(posedge clock) begin
		if (srst) begin
			ack_missing <= 1'b0;
			stop_seen <= 1'b0;
			arbitration_lost <= 1'b0;
			bus_fault <= 1'b0;
		end else begin
			ack_missing <= next_ack_missing;
			stop_seen <= next_stop_seen;
			arbitration_lost <= next_arbitration_lost;
			bus_fault <= next_bus_fault;
		end
	end

	// Built from next values so it never lags its sources
	always_ff @(posedge clock) begin
		if (srst) begin
			event_pending <= 1'b0;
		end else begin
			event_pending <= next_byte_done || next_own_address_hit || next_start_generated
				|| next_ack_missing || next_stop_seen || next_arbitration_lost || next_bus_fault
				|| next_ten_bit_header_sent || next_addr_sent_flag;
		end
	end

	// Direction is only meaningful alongside byte_done
	always_ff @(posedge clock) begin
		if (srst) begin
			direction_transmit <= 1'b0;
		end else if (ev_tx_ack_pulse || ev_addr_phase_done) begin
			direction_transmit <= 1'b1;
		end else if (ev_rx_ack_pulse && ack_enable) begin
			direction_transmit <= 1'b0;
		end else if (!next_byte_done || stop_flag_set || ev_arb_lost || disabled) begin
			direction_transmit <= 1'b0;
		end
	end

	// Bus activity; a bus fault ends it as a Stop would
	always_ff @(posedge clock) begin
		if (srst) begin
			bus_busy <= 1'b0;
		end else if (start_cond) begin
			bus_busy <= 1'b1;
		end else if (stop_cond || ev_misplaced || disabled) begin
			bus_busy <= 1'b0;
		end
	end

	// Role; any detected Stop returns the block to slave
	always_ff @(posedge clock) begin
		if (srst) begin
			master_role <= 1'b0;
		end else if (wr_lane && sel_ctl && wb_dat_i[i2c_flag_pkg::CTL_START_REQUEST] && interface_enable) begin
			master_role <= 1'b1;
		end else if (stop_cond || ev_arb_lost || disabled) begin
			master_role <= 1'b0;
		end
	end

	// General call stays visible until the slave Stop
	always_ff @(posedge clock) begin
		if (srst) begin
			general_call_seen <= 1'b0;
		end else if (gc_match) begin
			general_call_seen <= 1'b1;
		end else if (stop_flag_set || disabled) begin
			general_call_seen <= 1'b0;
		end
	end

	// Without an acknowledge since Start, a Stop raises no flag
	always_ff @(posedge clock) begin
		if (srst) begin
			ack_since_start <= 1'b0;
		end else if (ev_tx_ack_pulse || ev_rx_ack_pulse || addr_match || gc_match) begin
			ack_since_start <= 1'b1;
		end else if (start_cond || stop_cond || disabled) begin
			ack_since_start <= 1'b0;
		end
	end

	// Status reads arm the data-register step of the two-step clears
	always_ff @(posedge clock) begin
		if (srst) begin
			primary_armed <= 1'b0;
		end else if (rd_sp) begin
			primary_armed <= 1'b1;
		end else if (dr_access || disabled) begin
			primary_armed <= 1'b0;
		end
	end

	// Any data access disarms, so a stale read cannot clear later
	always_ff @(posedge clock) begin
		if (srst) begin
			secondary_armed <= 1'b0;
		end else if (rd_ss) begin
			secondary_armed <= 1'b1;
		end else if (dr_access || disabled) begin
			secondary_armed <= 1'b0;
		end
	end

	// Software controls
	always_ff @(posedge clock) begin
		if (srst) begin
			interface_enable <= i2c_flag_pkg::RST_CONTROL[i2c_flag_pkg::CTL_INTERFACE_ENABLE];
			event_irq_enable <= i2c_flag_pkg::RST_CONTROL[i2c_flag_pkg::CTL_EVENT_IRQ_ENABLE];
			ack_enable <= i2c_flag_pkg::RST_CONTROL[i2c_flag_pkg::CTL_ACK_ENABLE];
			general_call_enable <= i2c_flag_pkg::RST_CONTROL[i2c_flag_pkg::CTL_GENERAL_CALL_ENABLE];
			start_request <= 1'b0;
		end else begin
			start_request <= 1'b0;
			if (wr_lane && sel_ctl) begin
				interface_enable <= wb_dat_i[i2c_flag_pkg::CTL_INTERFACE_ENABLE];
				event_irq_enable <= wb_dat_i[i2c_flag_pkg::CTL_EVENT_IRQ_ENABLE];
				ack_enable <= wb_dat_i[i2c_flag_pkg::CTL_ACK_ENABLE];
				general_call_enable <= wb_dat_i[i2c_flag_pkg::CTL_GENERAL_CALL_ENABLE];
				start_request <= wb_dat_i[i2c_flag_pkg::CTL_START_REQUEST] && interface_enable;
			end
		end
	end

	// Own slave address
	always_ff @(posedge clock) begin
		if (srst) begin
			own_address <= i2c_flag_pkg::RST_OWN_ADDRESS;
		end else if (wr_lane && sel_own) begin
			own_address <= wb_dat_i[6:0];
		end
	end

	// Transmit byte hand-off
	always_ff @(posedge clock) begin
		if (srst) begin
			tx_data <= 8'h00;
			tx_load <= 1'b0;
		end else begin
			tx_load <= dr_write;
			if (dr_write) begin
				tx_data <= wb_dat_i[7:0];
			end
		end
	end

	// Start, byte and own-address flags stretch; header, address-sent and error flags never do
	always_ff @(posedge clock) begin
		if (srst) begin
			scl_o <= 1'b0;
			scl_oe_n <= 1'b1;
		end else begin
			scl_o <= 1'b0;
			scl_oe_n <= !(next_byte_done || next_own_address_hit || next_start_generated);
		end
	end

	// Header and address-sent flags only raise event_pending
	always_ff @(posedge clock) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= event_irq_enable && (next_byte_done || next_own_address_hit || next_start_generated
				|| next_ack_missing || next_stop_seen || next_arbitration_lost || next_bus_fault);
		end
	end

	always_comb begin
		status_primary = i2c_flag_pkg::RST_STATUS;
		status_primary[i2c_flag_pkg::SP_EVENT_PENDING] = event_pending;
		status_primary[i2c_flag_pkg::SP_TEN_BIT_HEADER_SENT] = ten_bit_header_sent;
		status_primary[i2c_flag_pkg::SP_DIRECTION_TRANSMIT] = direction_transmit && byte_done;
		status_primary[i2c_flag_pkg::SP_BUS_BUSY] = bus_busy;
		status_primary[i2c_flag_pkg::SP_BYTE_DONE] = byte_done;
		status_primary[i2c_flag_pkg::SP_OWN_ADDRESS_HIT] = own_address_hit;
		status_primary[i2c_flag_pkg::SP_MASTER_ROLE] = master_role;
		status_primary[i2c_flag_pkg::SP_START_GENERATED] = start_generated;
		status_secondary = i2c_flag_pkg::RST_STATUS;
		status_secondary[i2c_flag_pkg::SS_ACK_MISSING] = ack_missing;
		status_secondary[i2c_flag_pkg::SS_STOP_SEEN] = stop_seen;
		status_secondary[i2c_flag_pkg::SS_ARBITRATION_LOST] = arbitration_lost;
		status_secondary[i2c_flag_pkg::SS_BUS_FAULT] = bus_fault;
		status_secondary[i2c_flag_pkg::SS_GENERAL_CALL_SEEN] = general_call_seen;
	end

	// One-wait-state slave; unmapped reads return zero and still ack
	always_ff @(posedge clock) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= access;
		end
	end

	// Read data holds until the next read is taken
	always_ff @(posedge clock) begin
		if (srst) begin
			wb_dat_o <= 32'h00000000;
		end else begin
			if (rd) begin
				if (sel_ctl) begin
					wb_dat_o <= {27'h0, 1'b0, general_call_enable, ack_enable, event_irq_enable,
						interface_enable};
				end else if (sel_own) begin
					wb_dat_o <= {25'h0, own_address};
				end else if (sel_sp) begin
					wb_dat_o <= {24'h000000, status_primary};
				end else if (sel_ss) begin
					wb_dat_o <= {24'h000000, status_secondary};
				end else if (sel_dr) begin
					wb_dat_o <= {24'h000000, rx_data};
				end else begin
					wb_dat_o <= 32'h00000000;
				end
			end
		end
	end
endmodule

`default_nettype wire

// *** test/i2c_status_flag_monitor.sv ***
// Port checker for the two-wire status flag block.
`timescale 1ns/1ps
`default_nettype none
module i2c_status_flag_monitor (
	input wire logic clock, // Clock
	input wire logic srst, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic wb_ack_o, // Ack
	input wire logic scl_oe_n, // Clock hold
	input wire logic ev_start_done, // Event
	input wire logic ev_addr_sent, // Event
	input wire logic ev_header_sent, // Event
	input wire logic ev_addr_phase_done, // Event
	input wire logic ev_tx_ack_pulse, // Event
	input wire logic ev_rx_ack_pulse, // Event
	input wire logic ev_no_ack, // Event
	input wire logic ev_arb_lost, // Event
	input wire logic ev_misplaced, // Event
	input wire logic ev_addr_rx, // Event
	input wire logic ack_enable, // Level
	input wire logic start_request, // Pulse
	input wire logic tx_load, // Load pulse
	input wire logic interface_enable, // Level
	input wire logic irq // Interrupt
);
	logic taken, hold_ev;
	assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Only these may set a stretching flag; the rest must leave the line free
	assign hold_ev = ev_start_done | ev_addr_sent | ev_header_sent | ev_addr_phase_done | ev_tx_ack_pulse
		| (ev_rx_ack_pulse & ack_enable) | ev_addr_rx;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	ack_single_a: assert property (taken |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
	tx_stretch_a: assert property (ev_tx_ack_pulse && interface_enable |=> !scl_oe_n) else $error("no tx hold");
	rx_stretch_a: assert property (ev_rx_ack_pulse && ack_enable && interface_enable |=> !scl_oe_n)
		else $error("no rx hold");
	hold_stays_a: assert property (!scl_oe_n && !taken && interface_enable |=> !scl_oe_n)
		else $error("hold lost");
	no_stretch_a: assert property (scl_oe_n && !hold_ev |=> scl_oe_n) else $error("bad hold");
	irq_fall_a: assert property ($fell(irq) |-> $past(taken) || $past(taken, 2)) else $error("irq dropped");
	disable_clear_a: assert property ($fell(interface_enable) |-> ##[0:1] (scl_oe_n && !irq))
		else $error("flags kept");
	start_pulse_a: assert property (start_request |=> !start_request) else $error("start too long");
	load_pulse_a: assert property (taken && wb_we_i && wb_sel_i[0] && wb_adr_i == i2c_flag_pkg::OFF_DATA_BUFFER
		|=> tx_load ##1 !tx_load) else $error("no load pulse");
	cover property ($fell(scl_oe_n));
	cover property (ev_start_done ##1 !scl_oe_n);
	cover property ($rose(irq));
	cover property (start_request);
endmodule
bind i2c_status_flag_logic i2c_status_flag_monitor i_mon (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_ack_o,
	.scl_oe_n, .ev_start_done, .ev_addr_sent, .ev_header_sent, .ev_addr_phase_done, .ev_tx_ack_pulse,
	.ev_rx_ack_pulse, .ev_no_ack, .ev_arb_lost, .ev_misplaced, .ev_addr_rx, .ack_enable, .start_request,
	.tx_load, .interface_enable, .irq);
`default_nettype wire

// *** test/i2c_bus_peer.sv ***
// Bus peer that frames Start and Stop conditions.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_peer (
	input wire logic scl_line, // Clock line
	output logic scl_drv, // Clock, 1 releases
	output logic sda_drv // Data, 1 releases
);
	// Lines idle on pull-ups; clock stands between frames
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic start_cond();
		#200 sda_drv = 1'b0;
		#200 scl_drv = 1'b0;
	endtask
	task automatic stop_cond();
		#200 scl_drv = 1'b1;
		wait (scl_line === 1'b1); // Held clock delays the Stop
		#200 sda_drv = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** test/i2c_status_flag_logic_tb_top.sv ***
// Bench for the two-wire status flag block.
`timescale 1ns/1ps
`default_nettype none
module i2c_status_flag_logic_tb_top;
	typedef struct packed {logic [7:0] c; logic [3:0] e; logic [6:0] a; logic [7:0] s1, s2; logic h, q;} row_t;
	logic clock, srst, cyc, stb, we, ack, scl_o, hold_n, irq, scl_drv, sda_drv;
	logic [7:0] adr, tx_data;
	logic [31:0] wdat, rdat, rd;
	logic [9:0] ev;
	logic [6:0] rxa;
	int errors = 0, checked = 0, cycles = 0;
	wire logic scl_line = scl_drv & (hold_n | scl_o);
	row_t rows [15] = '{'{8'h0F, 4'd0, 7'h00, 8'h81, 8'h00, 1'b0, 1'b1},
		'{8'h0F, 4'd1, 7'h00, 8'h80, 8'h00, 1'b1, 1'b0},
		'{8'h0F, 4'd2, 7'h00, 8'hC0, 8'h00, 1'b1, 1'b0},
		'{8'h0F, 4'd3, 7'h00, 8'hA8, 8'h00, 1'b0, 1'b1},
		'{8'h0F, 4'd4, 7'h00, 8'hA8, 8'h00, 1'b0, 1'b1},
		'{8'h0D, 4'd4, 7'h00, 8'hA8, 8'h00, 1'b0, 1'b0},
		'{8'h0F, 4'd5, 7'h00, 8'h88, 8'h00, 1'b0, 1'b1},
		'{8'h0B, 4'd5, 7'h00, 8'h00, 8'h00, 1'b1, 1'b0},
		'{8'h0F, 4'd6, 7'h00, 8'h80, 8'h10, 1'b1, 1'b1},
		'{8'h0F, 4'd7, 7'h00, 8'h80, 8'h04, 1'b1, 1'b1},
		'{8'h0F, 4'd8, 7'h00, 8'h80, 8'h02, 1'b1, 1'b1},
		'{8'h0F, 4'd9, 7'h2A, 8'h84, 8'h00, 1'b0, 1'b1},
		'{8'h0F, 4'd9, 7'h00, 8'h84, 8'h01, 1'b0, 1'b1},
		'{8'h07, 4'd9, 7'h00, 8'h00, 8'h00, 1'b1, 1'b0},
		'{8'h0F, 4'd9, 7'h15, 8'h00, 8'h00, 1'b1, 1'b0}};
	i2c_status_flag_logic i_dut (.clock, .srst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl_line), .scl_o,
		.scl_oe_n(hold_n), .sda_i(sda_drv), .ev_start_done(ev[0]), .ev_addr_sent(ev[1]), .ev_header_sent(ev[2]),
		.ev_addr_phase_done(ev[3]), .ev_tx_ack_pulse(ev[4]), .ev_rx_ack_pulse(ev[5]), .ev_no_ack(ev[6]),
		.ev_arb_lost(ev[7]), .ev_misplaced(ev[8]), .ev_addr_rx(ev[9]), .rx_addr(rxa), .rx_data(8'hC3),
		.tx_data, .tx_load(), .start_request(), .interface_enable(), .ack_enable(), .general_call_enable(),
		.own_address(), .irq);
	i2c_bus_peer i_peer (.scl_line, .scl_drv, .sda_drv);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("Compared %0d, mismatched %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		checked++;
		if (s !== x) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clock);
		while (ack !== 1'b1) @(posedge clock);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] x);
		wb(1'b0, a, 32'h0);
		chk(n, {24'h0, x}, rd);
	endtask
	// Disable first so every case starts from cleared flags
	task automatic fresh(input logic [7:0] c);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b1, 8'h00, {24'h0, c});
	endtask
	task automatic pulse(input logic [3:0] i);
		@(posedge clock);
		ev <= 10'h001 << i;
		@(posedge clock);
		ev <= 10'h000;
		@(negedge clock);
	endtask
	initial begin
		srst = 1'b1;
		{cyc, stb, we, adr, wdat, ev, rxa} = '0;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		rdc("primary", 8'h08, 8'h00);
		rdc("secondary", 8'h0C, 8'h00);
		rdc("unmapped", 8'h14, 8'h00);
		wb(1'b1, 8'h04, 32'h2A);
		rdc("own", 8'h04, 8'h2A);
		$display("Reset test done");
		foreach (rows[i]) begin
			fresh(rows[i].c);
			rxa <= rows[i].a;
			pulse(rows[i].e);
			chk("scl_oe_n", {31'h0, rows[i].h}, {31'h0, hold_n});
			chk("irq", {31'h0, rows[i].q}, {31'h0, irq});
			rdc("primary", 8'h08, rows[i].s1);
			rdc("secondary", 8'h0C, rows[i].s2);
			rdc("control", 8'h00, {4'h0, rows[i].c[3:0]});
			$display("Row %0d done", i);
		end
		fresh(8'h0F);
		pulse(4'd4);
		wb(1'b1, 8'h10, 32'h5A);
		rdc("primary", 8'h08, 8'hA8);
		wb(1'b1, 8'h10, 32'h5A);
		rdc("primary", 8'h08, 8'h00);
		chk("tx_data", 32'h5A, {24'h0, tx_data});
		pulse(4'd5);
		rdc("primary", 8'h08, 8'h88);
		rdc("data", 8'h10, 8'hC3);
		rdc("primary", 8'h08, 8'h00);
		pulse(4'd2);
		rdc("secondary", 8'h0C, 8'h00);
		wb(1'b1, 8'h10, 32'h78);
		rdc("primary", 8'h08, 8'h00);
		$display("Two-step clear test done");
		wb(1'b1, 8'h00, 32'h1F);
		rdc("primary", 8'h08, 8'h02);
		pulse(4'd0);
		rdc("primary", 8'h08, 8'h83);
		wb(1'b1, 8'h10, 32'h54);
		rdc("primary", 8'h08, 8'h02);
		pulse(4'd7);
		rdc("primary", 8'h08, 8'h80);
		rdc("secondary", 8'h0C, 8'h04);
		rdc("primary", 8'h08, 8'h00);
		$display("Master test done");
		i_peer.start_cond();
		repeat (10) @(posedge clock);
		rdc("primary", 8'h08, 8'h10);
		pulse(4'd8);
		rdc("primary", 8'h08, 8'h80);
		rdc("secondary", 8'h0C, 8'h02);
		i_peer.stop_cond();
		i_peer.start_cond();
		repeat (10) @(posedge clock);
		rxa <= 7'h00;
		pulse(4'd9);
		rdc("primary", 8'h08, 8'h94);
		i_peer.stop_cond();
		repeat (10) @(posedge clock);
		rdc("secondary", 8'h0C, 8'h08);
		rdc("primary", 8'h08, 8'h00);
		$display("Bus line test done");
		pulse(4'd4);
		@(posedge clock);
		srst <= 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chk("scl_oe_n", 32'h1, {31'h0, hold_n});
		rdc("primary", 8'h08, 8'h00);
		$display("Mid-run reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
